// file: pkg/mmd_pkg.sv
// Constants and carrier types of the memory map decoder with boot selection and remap.
package mmd_pkg;
   // ==========================================================
   // Address map
   localparam logic [3:0] INT_NIB = 4'h0;
   localparam logic [3:0] PERIPH_NIB = 4'hF;
   localparam logic [7:0] AREA_BOOT = 8'h00;
   localparam logic [7:0] AREA_FLASH = 8'h01;
   localparam logic [7:0] AREA_CSRAM = 8'h02;
   localparam logic [7:0] AREA_BSRAM = 8'h03;
   localparam logic [7:0] AREA_ROM = 8'h04;
   localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
   localparam logic [31:0] CSRAM_BASE = 32'h0020_0000;
   localparam logic [31:0] BSRAM_BASE = 32'h0030_0000;
   localparam logic [31:0] ROM_BASE = 32'h0040_0000;
   localparam logic [31:0] CONTIG_BASE = 32'h002F_F000;
   localparam logic [31:0] UNDEF_BASE = 32'h0050_0000;
   localparam logic [31:0] UNDEF_LAST = 32'h0FFF_FFFF;
   localparam logic [27:0] CSRAM_MASK = 28'h000_0FFF;
   localparam logic [27:0] BSRAM_MASK = 28'h000_07FF;
   localparam logic [27:0] AREA_MASK = 28'h00F_FFFF;
   localparam int AREA_SEL_W = 6;
   localparam int SEL_BOOT = 0;
   localparam int SEL_FLASH = 1;
   localparam int SEL_CSRAM = 2;
   localparam int SEL_BSRAM = 3;
   localparam int SEL_ROM = 4;
   localparam int SEL_PERIPH = 5;
   // ==========================================================
   // Access sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   // ==========================================================
   // Wipe input filter timing
   localparam int WIPE_MIN_MS = 100;
   localparam int SCLK_HZ = 32768;
   localparam int WIPE_MIN_TICKS = (WIPE_MIN_MS * SCLK_HZ + 999) / 1000;
   localparam int WIPE_CNT_W = 12;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      TGT_NONE, TGT_ROM, TGT_FLASH, TGT_CSRAM, TGT_BSRAM, TGT_PERIPH
   } mmd_tgt_type;
   typedef enum logic [1:0] {ABT_NONE, ABT_MISALIGN, ABT_UNDEF, ABT_PROT} mmd_abt_kind_type;
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [1:0] size;
      logic write;
      logic user;
      logic src;
      logic instr;
   } mmd_req_type;
   typedef struct packed {
      logic valid;
      mmd_tgt_type tgt;
      logic [AREA_SEL_W-1:0] area;
      logic [27:0] offset;
   } mmd_route_type;
   typedef struct packed {
      logic src;
      mmd_abt_kind_type kind;
      logic [31:0] addr;
      logic [1:0] size;
      logic write;
   } mmd_abt_type;
endpackage

// file: src/mmd_decoder.sv
// Memory map decoder with boot selection, remap, abort logging and wipe input filter.
`timescale 1ns/1ns
module mmd_decoder #(
   parameter int WIPE_TICKS = mmd_pkg::WIPE_MIN_TICKS
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Bus master access
   input wire mmd_pkg::mmd_req_type req,
   // Control
   input wire logic remap_cmd,
   input wire logic boot_set,
   input wire logic boot_clr,
   input wire logic boot_nvm_in,
   input wire logic prot_wr,
   input wire logic prot_user,
   // Wipe input and slow clock
   input wire logic wipe_in,
   input wire logic sclk,
   // Results
   output mmd_pkg::mmd_route_type route_r,
   output logic abort_r,
   output mmd_pkg::mmd_abt_type abt_stat_r,
   output logic remap_r,
   output logic boot_select_nvm_bit_r,
   output logic wipe_ok_r
);
   // ==========================================================
   // Decode helpers
   function automatic logic misaligned(input logic [1:0] size, input logic [1:0] a);
      if (size == mmd_pkg::SIZE_BYTE) begin
         misaligned = 1'b0;
      end else if (size == mmd_pkg::SIZE_HALF) begin
         misaligned = a[0];
      end else begin
         misaligned = |a;
      end
   endfunction

   function automatic logic in_area(input logic [31:0] a, input logic [31:0] base);
      in_area = (a[31:20] == base[31:20]);
   endfunction

   logic loaded_r;
   logic sclk_q_r;
   logic wipe_hold_r;
   logic [mmd_pkg::WIPE_CNT_W-1:0] wipe_cnt_r;
   mmd_pkg::mmd_tgt_type tgt;
   mmd_pkg::mmd_abt_kind_type kind;
   logic [mmd_pkg::AREA_SEL_W-1:0] asel;
   logic [27:0] off;
   logic is_int;
   logic is_per;
   logic tick;
   logic wipe_hit;

   // ==========================================================
   // Address decode
   always_comb begin
      is_int = (req.addr[31:28] == mmd_pkg::INT_NIB);
      is_per = (req.addr[31:28] == mmd_pkg::PERIPH_NIB);
      tgt = mmd_pkg::TGT_NONE;
      asel = '0;
      off = req.addr[27:0] & mmd_pkg::AREA_MASK;
      if (is_int) begin
         case (req.addr[27:20])
            mmd_pkg::AREA_BOOT: begin
               asel[mmd_pkg::SEL_BOOT] = 1'b1;
               if (remap_r) begin
                  tgt = mmd_pkg::TGT_CSRAM;
                  off = req.addr[27:0] & mmd_pkg::CSRAM_MASK;
               end else begin
                  tgt = boot_select_nvm_bit_r ? mmd_pkg::TGT_FLASH : mmd_pkg::TGT_ROM;
               end
            end
            mmd_pkg::AREA_FLASH: begin
               asel[mmd_pkg::SEL_FLASH] = 1'b1;
               tgt = mmd_pkg::TGT_FLASH;
            end
            mmd_pkg::AREA_CSRAM: begin
               asel[mmd_pkg::SEL_CSRAM] = 1'b1;
               tgt = mmd_pkg::TGT_CSRAM;
               off = req.addr[27:0] & mmd_pkg::CSRAM_MASK;
            end
            mmd_pkg::AREA_BSRAM: begin
               asel[mmd_pkg::SEL_BSRAM] = 1'b1;
               tgt = mmd_pkg::TGT_BSRAM;
               off = req.addr[27:0] & mmd_pkg::BSRAM_MASK;
            end
            mmd_pkg::AREA_ROM: begin
               asel[mmd_pkg::SEL_ROM] = 1'b1;
               tgt = mmd_pkg::TGT_ROM;
            end
            default: begin
               tgt = mmd_pkg::TGT_NONE;
            end
         endcase
      end else if (is_per) begin
         asel[mmd_pkg::SEL_PERIPH] = 1'b1;
         tgt = mmd_pkg::TGT_PERIPH;
         off = req.addr[27:0];
      end
      // Misalignment is reported ahead of decode and protection faults.
      if (!req.instr && misaligned(req.size, req.addr[1:0])) begin
         kind = mmd_pkg::ABT_MISALIGN;
      end else if (tgt == mmd_pkg::TGT_NONE) begin
         kind = mmd_pkg::ABT_UNDEF;
      end else if (is_per && ((prot_wr && req.write) || (prot_user && req.user))) begin
         kind = mmd_pkg::ABT_PROT;
      end else begin
         kind = mmd_pkg::ABT_NONE;
      end
   end

   // ==========================================================
   // Route and abort outputs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         route_r <= '0;
         abort_r <= 1'b0;
      end else if (clk_en) begin
         route_r.valid <= req.valid && (kind == mmd_pkg::ABT_NONE);
         route_r.tgt <= tgt;
         route_r.area <= asel;
         route_r.offset <= off;
         abort_r <= req.valid && (kind != mmd_pkg::ABT_NONE);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         abt_stat_r <= '0;
      end else if (clk_en && req.valid && (kind != mmd_pkg::ABT_NONE)) begin
         abt_stat_r <= {req.src, kind, req.addr, req.size, req.write};
      end
   end

   // ==========================================================
   // Remap state
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         remap_r <= 1'b0;
      end else if (clk_en && remap_cmd) begin
         remap_r <= 1'b1;
      end
   end

   // ==========================================================
   // Boot select bit, loaded from the array after reset release
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         loaded_r <= 1'b0;
         boot_select_nvm_bit_r <= 1'b0;
      end else if (clk_en) begin
         loaded_r <= 1'b1;
         if (wipe_hit) begin
            boot_select_nvm_bit_r <= 1'b0;
         end else if (!loaded_r) begin
            boot_select_nvm_bit_r <= boot_nvm_in;
         end else if (boot_set) begin
            boot_select_nvm_bit_r <= 1'b1;
         end else if (boot_clr) begin
            boot_select_nvm_bit_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Wipe input filter on slow clock rising edges
   localparam int WIPE_CNT_W = mmd_pkg::WIPE_CNT_W;

   // Acceptance waits for WIPE_TICKS whole slow periods after the first tick, so a high
   // level shorter than the minimum can never pass, whatever its phase to the slow clock.
   assign tick = sclk && !sclk_q_r;
   assign wipe_hit = tick && wipe_in && !wipe_hold_r &&
                     (wipe_cnt_r == WIPE_CNT_W'(WIPE_TICKS));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_q_r <= 1'b0;
         wipe_cnt_r <= '0;
         wipe_hold_r <= 1'b0;
         wipe_ok_r <= 1'b0;
      end else if (clk_en) begin
         sclk_q_r <= sclk;
         wipe_ok_r <= wipe_hit;
         if (!wipe_in) begin
            wipe_cnt_r <= '0;
            wipe_hold_r <= 1'b0;
         end else if (tick && !wipe_hold_r) begin
            wipe_cnt_r <= wipe_cnt_r + 1'b1;
            wipe_hold_r <= wipe_hit;
         end
      end
   end

   // ==========================================================
   // Checks
   flash_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && req.valid && in_area(req.addr, mmd_pkg::FLASH_BASE) &&
      (req.instr || !misaligned(req.size, req.addr[1:0]))
      |=> route_r.valid && route_r.tgt == mmd_pkg::TGT_FLASH)
      else $error("flash window not routed to flash");
   csram_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && !remap_r && req.addr[31:20] == '0
      |=> route_r.tgt != mmd_pkg::TGT_CSRAM)
      else $error("core sram seen at zero before remap");
   bsram_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && in_area(req.addr, mmd_pkg::BSRAM_BASE)
      |=> route_r.tgt == mmd_pkg::TGT_BSRAM && route_r.area[mmd_pkg::SEL_BSRAM])
      else $error("backup sram window misrouted");
   remap_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && remap_r && req.addr[31:20] == '0
      |=> route_r.tgt == mmd_pkg::TGT_CSRAM && route_r.offset[27:12] == '0)
      else $error("core sram missing at zero after remap");
   contig_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && req.addr[31:12] == mmd_pkg::CONTIG_BASE[31:12]
      |=> route_r.tgt == mmd_pkg::TGT_CSRAM && route_r.offset == $past(req.addr[11:0]))
      else $error("contiguous sram base not core sram");
   rom_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && in_area(req.addr, mmd_pkg::ROM_BASE)
      |=> route_r.tgt == mmd_pkg::TGT_ROM)
      else $error("rom window misrouted");
   boot_pick_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && !remap_r && req.addr[31:20] == '0
      |=> route_r.tgt == ($past(boot_select_nvm_bit_r) ? mmd_pkg::TGT_FLASH : mmd_pkg::TGT_ROM))
      else $error("boot selection at zero wrong");
   wipe_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && wipe_hit |=> !boot_select_nvm_bit_r && wipe_ok_r)
      else $error("accepted wipe left boot bit set");
   misalign_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && req.valid && !req.instr && misaligned(req.size, req.addr[1:0])
      |=> abort_r && !route_r.valid && abt_stat_r.kind == mmd_pkg::ABT_MISALIGN)
      else $error("misaligned access not aborted");
   abt_log_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en ##1 abort_r |-> abt_stat_r.addr == $past(req.addr) &&
      abt_stat_r.src == $past(req.src) && abt_stat_r.write == $past(req.write))
      else $error("abort parameters not logged");
   prot_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && req.valid && req.addr[31:28] == mmd_pkg::PERIPH_NIB && prot_wr && req.write
      |=> abort_r)
      else $error("protected peripheral write not aborted");
   undef_a: assert property (@(posedge mclk) disable iff (!arst_n)
      clk_en && req.valid && req.addr >= mmd_pkg::UNDEF_BASE && req.addr <= mmd_pkg::UNDEF_LAST
      |=> abort_r && !route_r.valid)
      else $error("undefined range access not aborted");
   wipe_short_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !wipe_in |=> wipe_cnt_r == '0 || !$past(clk_en))
      else $error("wipe filter not restarted on low");
endmodule

// file: test/mmd_wipe_src.sv
// Slow clock source and wipe pin driver standing outside the decoder.
`timescale 1ns/1ns
module mmd_wipe_src #(
   parameter int SCLK_HALF = 4
) (
   // Clock
   input wire logic mclk,
   // Command from the bench
   input wire logic start,
   input wire logic [7:0] ticks,
   // Pins
   output logic sclk,
   output logic wipe_in,
   output logic busy
);
   int div = 0;
   int cnt = 0;
   // The test pin stays low, so the device never enters fast programming mode here.
   logic test_select_input = 1'b0;
   initial begin
      sclk = 1'b0;
      wipe_in = 1'b0;
      busy = 1'b0;
   end
   // ==========================================================
   // Slow clock and pin level; the pin pull-down gives 0 when released.
   always @(posedge mclk) begin
      div <= (div == SCLK_HALF - 1) ? 0 : div + 1;
      if (div == SCLK_HALF - 1) begin
         sclk <= ~sclk;
      end
      if (start && !busy) begin
         busy <= 1'b1;
         wipe_in <= 1'b1;
         cnt <= 0;
      end else if (busy && div == SCLK_HALF - 1) begin
         if (!sclk) begin
            cnt <= cnt + 1;
         end else if (cnt >= int'(ticks)) begin
            wipe_in <= 1'b0;
            busy <= 1'b0;
         end
      end
   end
endmodule

// file: test/testbench.sv
// Self-checking bench for the memory map decoder.
`timescale 1ns/1ns
module testbench;
   typedef struct {
      logic [31:0] addr;
      logic [1:0] size;
      logic [5:0] flg;
      logic [2:0] tgt;
      logic [5:0] area;
      logic [27:0] off;
      logic [1:0] kind;
   } mmd_row_type;
   // Flags are write, user, source, fetch, write protect, user protect.
   mmd_row_type rows [18] = '{
      '{32'h0010_0004, 2'h2, 6'h00, 3'h2, 6'h02, 28'h4, 2'h0},
      '{32'h0020_0010, 2'h2, 6'h00, 3'h3, 6'h04, 28'h10, 2'h0},
      '{32'h0030_0804, 2'h2, 6'h00, 3'h4, 6'h08, 28'h4, 2'h0},
      '{32'h0040_0100, 2'h1, 6'h00, 3'h1, 6'h10, 28'h100, 2'h0},
      '{32'h002F_F000, 2'h2, 6'h00, 3'h3, 6'h04, 28'h0, 2'h0},
      '{32'h0030_0000, 2'h0, 6'h00, 3'h4, 6'h08, 28'h0, 2'h0},
      '{32'h0000_0008, 2'h2, 6'h00, 3'h1, 6'h01, 28'h8, 2'h0},
      '{32'hF000_1234, 2'h2, 6'h28, 3'h5, 6'h20, 28'h1234, 2'h0},
      '{32'h0010_0002, 2'h2, 6'h00, 3'h0, 6'h00, 28'h0, 2'h1},
      '{32'h0010_0001, 2'h1, 6'h28, 3'h0, 6'h00, 28'h0, 2'h1},
      '{32'h0010_0003, 2'h0, 6'h00, 3'h2, 6'h02, 28'h3, 2'h0},
      '{32'h0010_0002, 2'h2, 6'h04, 3'h2, 6'h02, 28'h2, 2'h0},
      '{32'h0050_0000, 2'h2, 6'h00, 3'h0, 6'h00, 28'h0, 2'h2},
      '{32'h1000_0000, 2'h2, 6'h20, 3'h0, 6'h00, 28'h0, 2'h2},
      '{32'h0050_0002, 2'h2, 6'h00, 3'h0, 6'h00, 28'h0, 2'h1},
      '{32'hF000_0000, 2'h2, 6'h22, 3'h0, 6'h00, 28'h0, 2'h3},
      '{32'hF000_0004, 2'h2, 6'h11, 3'h0, 6'h00, 28'h0, 2'h3},
      '{32'hF000_0008, 2'h2, 6'h12, 3'h5, 6'h20, 28'h8, 2'h0}
   };
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   mmd_pkg::mmd_req_type req = '0;
   logic remap_cmd = 1'b0;
   logic boot_set = 1'b0;
   logic boot_clr = 1'b0;
   logic boot_nvm_in = 1'b0;
   logic prot_wr = 1'b0;
   logic prot_user = 1'b0;
   logic start = 1'b0;
   logic [7:0] ticks = 8'h00;
   logic sclk;
   logic wipe_in;
   logic busy;
   mmd_pkg::mmd_route_type route_r;
   logic abort_r;
   mmd_pkg::mmd_abt_type abt_stat_r;
   logic remap_r;
   logic boot_r;
   logic wipe_ok_r;
   logic seen_ok = 1'b0;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;
   always #25 mclk = ~mclk;
   mmd_decoder #(.WIPE_TICKS(4)) mmd_decoder_i (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
      .req(req), .remap_cmd(remap_cmd), .boot_set(boot_set), .boot_clr(boot_clr),
      .boot_nvm_in(boot_nvm_in), .prot_wr(prot_wr), .prot_user(prot_user), .wipe_in(wipe_in),
      .sclk(sclk), .route_r(route_r), .abort_r(abort_r), .abt_stat_r(abt_stat_r),
      .remap_r(remap_r), .boot_select_nvm_bit_r(boot_r), .wipe_ok_r(wipe_ok_r));
   mmd_wipe_src #(.SCLK_HALF(4)) mmd_wipe_src_i (.mclk(mclk), .start(start), .ticks(ticks),
      .sclk(sclk), .wipe_in(wipe_in), .busy(busy));
   // ==========================================================
   // Tasks
   task automatic final_report();
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [5:0] f);
      @(posedge mclk);
      req <= '{1'b1, a, s, f[5], f[4], f[3], f[2]};
      prot_wr <= f[1];
      prot_user <= f[0];
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rst();
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      #1;
      chk({route_r.valid, abort_r, remap_r, boot_r, wipe_ok_r}, 40'h0);
      @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task automatic wipe(input logic [7:0] n);
      seen_ok = 1'b0;
      @(posedge mclk);
      start <= 1'b1;
      ticks <= n;
      @(posedge mclk);
      start <= 1'b0;
      #1;
      for (int k = 0; k < 300 && busy !== 1'b0; k++) begin
         @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
      #1;
   endtask
   always @(posedge mclk) begin
      if (wipe_ok_r === 1'b1) begin
         seen_ok = 1'b1;
      end
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst();
      foreach (rows[i]) begin
         acc(rows[i].addr, rows[i].size, rows[i].flg);
         if (rows[i].kind == 2'h0) begin
            chk({route_r, abort_r}, {1'b1, rows[i].tgt, rows[i].area, rows[i].off, 1'b0});
         end else begin
            chk({route_r.valid, abort_r, abt_stat_r}, {2'b01, rows[i].flg[3], rows[i].kind,
               rows[i].addr, rows[i].size, rows[i].flg[5]});
         end
      end
      @(posedge mclk);
      remap_cmd <= 1'b1;
      @(posedge mclk);
      remap_cmd <= 1'b0;
      acc(32'h0000_0010, 2'h2, 6'h00);
      chk({remap_r, route_r, abort_r}, {2'b11, 3'h3, 6'h01, 28'h10, 1'b0});
      acc(32'h0010_0000, 2'h2, 6'h00);
      chk({route_r, abort_r}, {1'b1, 3'h2, 6'h02, 28'h0, 1'b0});
      @(posedge mclk);
      boot_nvm_in <= 1'b1;
      rst();
      acc(32'h0000_0020, 2'h2, 6'h00);
      chk({remap_r, route_r, abort_r}, {2'b01, 3'h2, 6'h01, 28'h20, 1'b0});
      wipe(8'h03);
      chk({seen_ok, boot_r}, 40'h1);
      wipe(8'h06);
      chk({seen_ok, boot_r}, 40'h2);
      acc(32'h0000_0004, 2'h2, 6'h00);
      chk({route_r, abort_r}, {1'b1, 3'h1, 6'h01, 28'h4, 1'b0});
      @(posedge mclk);
      boot_set <= 1'b1;
      boot_clr <= 1'b1;
      @(posedge mclk);
      boot_set <= 1'b0;
      #1;
      chk(boot_r, 40'h1);
      @(posedge mclk);
      boot_clr <= 1'b0;
      #1;
      chk(boot_r, 40'h0);
      // With the enable low a new access must leave the registered route untouched.
      @(posedge mclk);
      clk_en <= 1'b0;
      acc(32'h0040_0000, 2'h2, 6'h00);
      chk({route_r, abort_r}, {1'b1, 3'h1, 6'h01, 28'h4, 1'b0});
      final_report();
   end
endmodule
